//--- common/upi_pkg.sv
// Operation
// - enable bit on powers module; off idles outputs, frees pins, stops analog
// - suspend bit gates the 48 MHz clock and puts transceiver in low power
// - busy reads 1 while active or still settling; 0 only when ready
// - sleep guard blocks sleep on bus activity or pending notification
// - activity pending reads 1 when activity seen but interrupt not yet raised
// - hardware sets flags; software writes 1 to clear, 0 leaves unchanged
// - stall flag on stall handshake received as host or sent as device
// - attach flag in host mode after 2.5 us quiet, bus not SE0
// - resume flag when K state holds for 2.5 us
// - idle flag after 3 ms of continuous idle bus
// - token done flag when current token processing finishes
// - clearing token done flag advances the endpoint status queue
// - frame start flag on SOF received or host SOF threshold
// - error summary set only by errors whose enables are set
// - bit 0 flags bus reset as device, detach as host
// - each enable bit gates the flag at the same position
// - error interrupt reaches request only with enable bit 1 set
// - enable bit 0 means reset enable as device, detach enable as host
// - unused bits read zero, ignore writes; implemented bits reset to zero
package upi_pkg;
  localparam logic [7:0] OFS_PWR   = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_IE    = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  // power control fields
  localparam int PWR_EN   = 0;
  localparam int PWR_SUSP = 1;
  localparam int PWR_BUSY = 3;
  localparam int PWR_GRD  = 4;
  localparam int PWR_ACT  = 7;
  localparam logic [7:0] PWR_WMASK = 8'h13;
  // interrupt flag positions
  localparam int F_RST    = 0;
  localparam int F_ERR    = 1;
  localparam int F_SOF    = 2;
  localparam int F_TOKEN  = 3;
  localparam int F_IDLE   = 4;
  localparam int F_RESUME = 5;
  localparam int F_ATTACH = 6;
  localparam int F_STALL  = 7;
  localparam logic [7:0] W1C_MASK = 8'hFD;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINE_WAIT_NS  = 2500;
  localparam int IDLE_WAIT_US  = 3000;
  localparam int LINE_WAIT_CYC =
    (LINE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_WAIT_CYC = IDLE_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [3:0] BUSY_SETTLE = 4'h8;
  // bus signalling
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_K   = 2'b01,
    LS_J   = 2'b10,
    LS_SE1 = 2'b11
  } upi_line_t;
  typedef enum logic {
    AT_DETACHED = 1'b0,
    AT_ATTACHED = 1'b1
  } upi_attach_t;
endpackage

//--- src/upi_ctrl.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
module upi_ctrl #(
  parameter int ADDR_W      = 8,
  parameter int LINE_CYCLES = upi_pkg::LINE_WAIT_CYC,
  parameter int IDLE_CYCLES = upi_pkg::IDLE_WAIT_CYC
) (
  input  wire logic        clock,          // 50 MHz system clock
  input  wire logic        resetn,         // async reset, active low
  input  wire logic [ADDR_W-1:0] s_awaddr, // write address
  input  wire logic        s_awvalid,      // write address valid
  output logic             s_awready,      // write address ready
  input  wire logic [31:0] s_wdata,        // write data
  input  wire logic [3:0]  s_wstrb,        // byte enables
  input  wire logic        s_wvalid,       // write data valid
  output logic             s_wready,       // write data ready
  output logic [1:0]       s_bresp,        // write response
  output logic             s_bvalid,       // write response valid
  input  wire logic        s_bready,       // write response ready
  input  wire logic [ADDR_W-1:0] s_araddr, // read address
  input  wire logic        s_arvalid,      // read address valid
  output logic             s_arready,      // read address ready
  output logic [31:0]      s_rdata,        // read data
  output logic [1:0]       s_rresp,        // read response
  output logic             s_rvalid,       // read data valid
  input  wire logic        s_rready,       // read data ready
  input  wire logic        dp_pin,         // D+ line level, async
  input  wire logic        dm_pin,         // D- line level, async
  input  wire logic        host_mode_enable, // 1 host, 0 device
  input  wire logic        ev_stall,       // stall handshake pulse
  input  wire logic        ev_token_done,  // token finished pulse
  input  wire logic        ev_sof,         // frame start pulse
  input  wire logic [7:0]  error_flags,    // individual error flags
  input  wire logic [7:0]  error_enables,  // individual error enables
  output logic             module_interrupt_request, // interrupt out
  output logic             stat_fifo_advance, // status queue pop pulse
  output logic             sleep_block,    // vetoes system sleep
  output logic             usb_clk_en,     // 48 MHz clock gate enable
  output logic             xcvr_low_power, // transceiver low power
  output logic             analog_en,      // analog front end on
  output logic             pins_owned      // pins used by the module
);

  ////////////////////////////////////////////////////////////////////
  // parameter checks
  generate
    if (LINE_CYCLES < 1 || IDLE_CYCLES <= LINE_CYCLES || ADDR_W < 8)
    begin : g_bad
      $error("upi_ctrl: unsupported parameter values");
    end
  endgenerate

  localparam int CNT_W = $clog2(IDLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] LINE_HIT = CNT_W'(LINE_CYCLES - 1);
  localparam logic [CNT_W-1:0] IDLE_HIT = CNT_W'(IDLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] IDLE_TOP = CNT_W'(IDLE_CYCLES);

  ////////////////////////////////////////////////////////////////////
  // state
  logic [1:0]  line_s1_r, line_s2_r, line_prev_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic        pwr_r, susp_r, grd_r, act_r, act_nxt;
  logic [3:0]  settle_r, settle_nxt;
  logic [7:0]  flags_r, flags_nxt, ie_r;
  logic        irq_r, adv_r, sleep_r;
  upi_pkg::upi_attach_t at_r, at_nxt;
  logic        aw_have_r, w_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]  wdata_r;
  logic        wstrb0_r;
  logic        bvalid_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;

  ////////////////////////////////////////////////////////////////////
  // line sampling: two flops before any logic looks at the pins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      // reset to idle J so leaving reset is not taken for a line change
      line_s1_r   <= upi_pkg::LS_J;
      line_s2_r   <= upi_pkg::LS_J;
      line_prev_r <= upi_pkg::LS_J;
    end else begin
      line_s1_r   <= {dp_pin, dm_pin};
      line_s2_r   <= line_s1_r;
      line_prev_r <= line_s2_r;
    end
  end

  // line decode; any change of line state counts as bus activity
  wire activity  = line_s2_r != line_prev_r;
  wire is_se0    = line_s2_r == upi_pkg::LS_SE0;
  wire is_k      = line_s2_r == upi_pkg::LS_K;
  wire is_j      = line_s2_r == upi_pkg::LS_J;
  wire line_hit  = pwr_r && !activity && cnt_r == LINE_HIT;
  wire idle_hit  = pwr_r && !activity && cnt_r == IDLE_HIT;
  wire run       = pwr_r && !susp_r;

  // stable-time counter saturates so the idle flag fires only once
  assign cnt_nxt = (!pwr_r || activity) ? '0 :
                   (cnt_r == IDLE_TOP) ? cnt_r : cnt_r + 1'b1;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) cnt_r <= '0;
    else         cnt_r <= cnt_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // attach tracking in host mode
  wire host = host_mode_enable;
  wire detached = at_r == upi_pkg::AT_DETACHED;
  always_comb begin
    at_nxt = at_r;
    case (at_r)
      upi_pkg::AT_DETACHED:
        if (host && line_hit && !is_se0) at_nxt = upi_pkg::AT_ATTACHED;
      upi_pkg::AT_ATTACHED:
        if (!host || (line_hit && is_se0)) at_nxt = upi_pkg::AT_DETACHED;
      default: at_nxt = upi_pkg::AT_DETACHED;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) at_r <= upi_pkg::AT_DETACHED;
    else         at_r <= at_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // flag set terms; a gated clock means no engine events in suspend
  wire set_stall  = run && ev_stall;
  wire set_attach = pwr_r && host && detached &&
                    line_hit && !is_se0;
  wire set_resume = pwr_r && line_hit && is_k;
  wire set_idle   = run && idle_hit && is_j;
  wire set_token  = run && ev_token_done;
  wire set_sof    = run && ev_sof;
  // a long SE0 is a reset as device, a detach once attached as host
  wire set_rst    = pwr_r && line_hit && is_se0 &&
                    (!host || !detached);
  wire err_lvl    = |(error_flags & error_enables);

  wire [7:0] set_vec;
  assign set_vec[upi_pkg::F_STALL]  = set_stall;
  assign set_vec[upi_pkg::F_ATTACH] = set_attach;
  assign set_vec[upi_pkg::F_RESUME] = set_resume;
  assign set_vec[upi_pkg::F_IDLE]   = set_idle;
  assign set_vec[upi_pkg::F_TOKEN]  = set_token;
  assign set_vec[upi_pkg::F_SOF]    = set_sof;
  assign set_vec[upi_pkg::F_ERR]    = 1'b0;
  assign set_vec[upi_pkg::F_RST]    = set_rst;

  ////////////////////////////////////////////////////////////////////
  // write decode
  wire wr_do   = aw_have_r && w_have_r && !bvalid_r;
  wire wa_pwr  = awaddr_r[7:0] == upi_pkg::OFS_PWR;
  wire wa_flg  = awaddr_r[7:0] == upi_pkg::OFS_FLAGS;
  wire wa_ie   = awaddr_r[7:0] == upi_pkg::OFS_IE;
  wire wa_hi   = ADDR_W > 8 && (awaddr_r >> 8) != '0;
  wire wa_ok   = !wa_hi && (wa_pwr || wa_flg || wa_ie);
  wire busy    = pwr_r || settle_r != 4'h0;
  // while disabled and settling only the power register may change
  wire wr_lock = !pwr_r && busy;
  wire wr_pwr  = wr_do && wstrb0_r && !wa_hi && wa_pwr;
  wire wr_flg  = wr_do && wstrb0_r && !wa_hi && wa_flg && !wr_lock;
  wire wr_ie   = wr_do && wstrb0_r && !wa_hi && wa_ie && !wr_lock;
  // writing 0 leaves a flag alone; error summary is read-only
  wire [7:0] clr_vec = wr_flg ? (wdata_r & upi_pkg::W1C_MASK)
                              : 8'h00;

  // set wins over a clear landing in the same cycle
  always_comb begin
    flags_nxt = (flags_r & ~clr_vec) | set_vec;
    flags_nxt[upi_pkg::F_ERR] = pwr_r && err_lvl;
  end

  // busy stays up for a settle time after the module is turned off
  assign settle_nxt = pwr_r ? upi_pkg::BUSY_SETTLE :
                      (settle_r != 4'h0) ? settle_r - 4'h1 : 4'h0;

  // activity seen in suspend waits until the resume flag is raised
  assign act_nxt = (susp_r && activity) ||
                   (act_r && susp_r && !set_resume);

  ////////////////////////////////////////////////////////////////////
  // control and status registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_r    <= 1'b0;
      susp_r   <= 1'b0;
      grd_r    <= 1'b0;
      ie_r     <= upi_pkg::REG_RESET;
      flags_r  <= upi_pkg::REG_RESET;
      settle_r <= 4'h0;
      act_r    <= 1'b0;
    end else begin
      if (wr_pwr) begin
        pwr_r  <= wdata_r[upi_pkg::PWR_EN];
        susp_r <= wdata_r[upi_pkg::PWR_SUSP];
        grd_r  <= wdata_r[upi_pkg::PWR_GRD];
      end
      if (wr_ie) ie_r <= wdata_r;
      flags_r  <= flags_nxt;
      settle_r <= settle_nxt;
      act_r    <= act_nxt;
    end
  end

  // interrupt, queue-advance and sleep outputs registered so they never glitch off decode logic
  wire irq_any = |(flags_r & ie_r);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_r   <= 1'b0;
      adv_r   <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      irq_r   <= irq_any;
      adv_r   <= clr_vec[upi_pkg::F_TOKEN] &&
                 flags_r[upi_pkg::F_TOKEN];
      sleep_r <= grd_r && (act_r || activity || irq_any);
    end
  end

  assign module_interrupt_request = irq_r;
  assign stat_fifo_advance = adv_r;
  assign sleep_block    = sleep_r;
  assign usb_clk_en     = pwr_r && !susp_r;
  assign xcvr_low_power = susp_r || !pwr_r;
  assign analog_en      = pwr_r;
  assign pins_owned     = pwr_r;

  ////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  assign s_awready = !aw_have_r && !bvalid_r;
  assign s_wready  = !w_have_r && !bvalid_r;
  assign s_bvalid  = bvalid_r;
  assign s_bresp   = bresp_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= upi_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_wdata[7:0];
        wstrb0_r <= s_wstrb[0];
      end
      if (wr_do) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wa_ok ? upi_pkg::RESP_OKAY : upi_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read decode; upper bits and unused fields read as zero
  wire [7:0] pwr_view = {act_r, 2'b00, grd_r, busy, 1'b0,
                         susp_r, pwr_r};
  wire ra_hi  = ADDR_W > 8 && (s_araddr >> 8) != '0;
  wire ra_pwr = !ra_hi && s_araddr[7:0] == upi_pkg::OFS_PWR;
  wire ra_flg = !ra_hi && s_araddr[7:0] == upi_pkg::OFS_FLAGS;
  wire ra_ie  = !ra_hi && s_araddr[7:0] == upi_pkg::OFS_IE;
  wire [7:0] rd_byte = ra_pwr ? pwr_view :
                       ra_flg ? flags_r :
                       ra_ie  ? ie_r : 8'h00;
  wire ra_ok = ra_pwr || ra_flg || ra_ie;

  assign s_arready = !rvalid_r;
  assign s_rvalid  = rvalid_r;
  assign s_rdata   = rdata_r;
  assign s_rresp   = rresp_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= upi_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= ra_ok ? upi_pkg::RESP_OKAY : upi_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_STALL_SET: assert property (
    set_stall |=> flags_r[upi_pkg::F_STALL])
    else $error("stall event did not set its flag");

  AST_W1C: assert property (
    clr_vec[upi_pkg::F_SOF] && !set_sof |=> !flags_r[upi_pkg::F_SOF])
    else $error("write one did not clear frame start flag");

  AST_W0_KEEP: assert property (
    wr_flg && flags_r[upi_pkg::F_IDLE] && !wdata_r[upi_pkg::F_IDLE]
    |=> flags_r[upi_pkg::F_IDLE])
    else $error("write zero changed idle flag");

  AST_IRQ: assert property (
    irq_any ##1 irq_any |-> module_interrupt_request)
    else $error("enabled flag without interrupt request");

  AST_BUSY: assert property (
    $fell(pwr_r) |-> busy [*8] ##1 (pwr_r || !busy))
    else $error("busy settle time wrong");

  AST_SUSP: assert property (
    $rose(flags_r[upi_pkg::F_TOKEN]) |-> $past(run))
    else $error("token flag set while suspended or off");

  AST_RESUME: assert property (
    $rose(flags_r[upi_pkg::F_RESUME])
    |-> $past(is_k) && $past(cnt_r) == LINE_HIT)
    else $error("resume flag without 2.5 us K state");

  AST_ERR: assert property (
    flags_r[upi_pkg::F_ERR] |-> $past(err_lvl))
    else $error("error summary set by masked error");

  AST_GUARD: assert property (
    !grd_r |=> !sleep_block)
    else $error("sleep blocked with guard off");

  AST_FIFO: assert property (
    clr_vec[upi_pkg::F_TOKEN] && flags_r[upi_pkg::F_TOKEN]
    |=> stat_fifo_advance ##1 (!stat_fifo_advance ||
        $past(clr_vec[upi_pkg::F_TOKEN] && flags_r[upi_pkg::F_TOKEN])))
    else $error("token clear did not advance status queue");

  AST_OFF: assert property (
    !pwr_r |-> !usb_clk_en && !analog_en && !pins_owned)
    else $error("disabled module still active");

  AST_ATTACH: assert property (
    $rose(flags_r[upi_pkg::F_ATTACH]) |-> $past(host) && !$past(is_se0))
    else $error("attach flag outside host mode or on SE0");

  AST_LINE_RST: assert property (
    $rose(flags_r[upi_pkg::F_RST])
    |-> $past(is_se0) && $past(cnt_r) == LINE_HIT)
    else $error("reset or detach flag without long SE0");

  AST_IDLE: assert property (
    $rose(flags_r[upi_pkg::F_IDLE])
    |-> $past(is_j) && $past(cnt_r) == IDLE_HIT)
    else $error("idle flag before the idle time elapsed");

  AST_TOKEN: assert property (
    set_token |=> flags_r[upi_pkg::F_TOKEN])
    else $error("token done event did not set its flag");

  AST_SOF: assert property (
    set_sof |=> flags_r[upi_pkg::F_SOF])
    else $error("frame start event did not set its flag");

  AST_PEND: assert property (
    !susp_r |=> !act_r)
    else $error("activity pending held outside suspend");

  COV_ATTACH: cover property (set_attach);
  COV_IDLE:   cover property (set_idle);
  COV_RESET:  cover property (set_rst && !host);
  COV_WRITE:  cover property (s_bvalid && s_bready);

endmodule // upi_ctrl

//--- dv/upi_bus_model.sv
////////////////////////////////////////////////////////////////////////////
// far end of the cable plus the packet engine that reports bus events
module upi_bus_model (
  input  wire logic clock,         // system clock
  output logic      dp_pin,        // D+ level
  output logic      dm_pin,        // D- level
  output logic      ev_stall,      // stall handshake pulse
  output logic      ev_token_done, // token done pulse
  output logic      ev_sof         // frame start pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  // a quiet full-speed bus idles in J, so the line counter starts calm
  initial begin
    {dp_pin, dm_pin} = upi_pkg::LS_J;
    {ev_stall, ev_token_done, ev_sof} = 3'h0;
  end

  // the line holds each state until the next call; a K held long is resume
  task automatic drive_line(input upi_pkg::upi_line_t s);
    @(posedge clock);
    {dp_pin, dm_pin} <= s;
  endtask

  // one-cycle event: 0 stall, 1 token done, 2 frame start
  task automatic pulse(input int k);
    @(posedge clock);
    ev_stall      <= (k == 0);
    ev_token_done <= (k == 1);
    ev_sof        <= (k == 2);
    @(posedge clock);
    {ev_stall, ev_token_done, ev_sof} <= 3'h0;
  endtask
endmodule // upi_bus_model

//--- dv/usb_power_and_interrupt_ctrl_test.sv
module usb_power_and_interrupt_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC    = 10;
  localparam int IC    = 300;
  localparam int LIMIT = 30000;
  localparam logic [7:0] A_P = upi_pkg::OFS_PWR;
  localparam logic [7:0] A_F = upi_pkg::OFS_FLAGS;
  localparam logic [7:0] A_E = upi_pkg::OFS_IE;
  logic clock = 1'b0;
  logic resetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [7:0] s_awaddr, s_araddr, error_flags, error_enables;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic dp, dm, e_st, e_tk, e_sf, host_mode_enable;
  logic module_interrupt_request, stat_fifo_advance, sleep_block;
  logic usb_clk_en, xcvr_low_power, analog_en, pins_owned;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int adv_cnt = 0;
  int seed;

  upi_ctrl #(.LINE_CYCLES(LC), .IDLE_CYCLES(IC)) uut (
    .clock(clock), .resetn(resetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .dp_pin(dp), .dm_pin(dm),
    .host_mode_enable(host_mode_enable), .ev_stall(e_st),
    .ev_token_done(e_tk), .ev_sof(e_sf), .error_flags(error_flags),
    .error_enables(error_enables),
    .module_interrupt_request(module_interrupt_request),
    .stat_fifo_advance(stat_fifo_advance), .sleep_block(sleep_block),
    .usb_clk_en(usb_clk_en), .xcvr_low_power(xcvr_low_power),
    .analog_en(analog_en), .pins_owned(pins_owned));
  upi_bus_model bus (.clock(clock), .dp_pin(dp), .dm_pin(dm),
    .ev_stall(e_st), .ev_token_done(e_tk), .ev_sof(e_sf));

  ////////////////////////////////////////////////////////////////////////
  // clock, queue-pop counter and hang guard
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (stat_fifo_advance === 1'b1) adv_cnt++;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("unexpected %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("mismatches %0d of %0d checks", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // both write channels offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= v;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    forever begin
      @(posedge clock);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) break;
    end
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clock);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    forever begin
      @(posedge clock);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) break;
    end
    {v, r} = {s_rdata, s_rresp};
    s_rready <= 1'b0;
  endtask

  function automatic logic [31:0] ev_bit(input int k);
    return (k == 0) ? 32'h80 : (k == 1) ? 32'h08 : 32'h04;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // main sequence; line waits are fixed by the stable-line counts
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] ie, ee, ef;
    int k, a0;
    seed = 32'hC0D07633;
    {resetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
    {s_awaddr, s_araddr, error_flags, error_enables} = 32'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    host_mode_enable = 1'b0;
    tick(10);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i), d, r);
      chk(d, 32'h0, "reset value");
    end
    rd(8'h0C, d, r);
    chk(32'(r), 32'(upi_pkg::RESP_SLVERR), "unmapped response");
    // resume interrupt stays off outside suspend
    wr(A_E, ({$random(seed)} & 32'hFFFFFF00) | 32'hDF);
    rd(A_E, d, r);
    chk(d, 32'hDF, "enable readback");
    wr(A_P, 32'hFFFFFF89);
    rd(A_P, d, r);
    chk(d, 32'h09, "power on");
    chk(32'({analog_en, pins_owned, usb_clk_en, xcvr_low_power}),
        32'hE, "powered outputs");
    tick(IC + 20);
    rd(A_F, d, r);
    chk(d, 32'h10, "idle flag");
    chk(32'(module_interrupt_request), 32'h1, "idle irq");
    wr(A_F, 32'h0);
    rd(A_F, d, r);
    chk(d, 32'h10, "zero write keeps");
    wr(A_F, 32'h10);
    rd(A_F, d, r);
    chk(d, 32'h0, "one clears");
    // random events under random enable masks
    for (int i = 0; i < 10; i++) begin
      ie = 8'($random(seed)) & 8'hDD;
      k = {$random(seed)} % 3;
      wr(A_E, 32'(ie));
      a0 = adv_cnt;
      bus.pulse(k);
      rd(A_F, d, r);
      chk(d, ev_bit(k), "event flag");
      chk(32'(module_interrupt_request), 32'(|(d[7:0] & ie)),
          "irq gate");
      wr(A_F, 32'hFF);
      tick(2);
      chk(32'(adv_cnt - a0), 32'(k == 1), "queue advance");
    end
    // error summary: first pass fully masked
    for (int i = 0; i < 5; i++) begin
      ee = (i == 0) ? 8'h00 : 8'($random(seed));
      ef = 8'($random(seed)) | 8'h01;
      ie = 8'($random(seed)) & 8'h02;
      error_enables <= ee;
      error_flags <= ef;
      wr(A_E, 32'(ie));
      wr(A_F, 32'h02);
      rd(A_F, d, r);
      chk(d, {30'h0, |(ef & ee), 1'b0}, "error summary");
      chk(32'(module_interrupt_request), 32'(ie[1] & |(ef & ee)),
          "error irq");
    end
    error_flags <= 8'h00;
    wr(A_E, 32'h0);
    bus.drive_line(upi_pkg::LS_SE0);
    tick(LC + 8);
    rd(A_F, d, r);
    chk(d & 32'h01, 32'h01, "device bus reset");
    bus.drive_line(upi_pkg::LS_K);
    tick(LC + 8);
    rd(A_F, d, r);
    chk(d & 32'h20, 32'h20, "resume");
    bus.drive_line(upi_pkg::LS_J);
    host_mode_enable <= 1'b1;
    wr(A_F, 32'hFF);
    bus.drive_line(upi_pkg::LS_SE0);
    tick(LC + 8);
    rd(A_F, d, r);
    chk(d & 32'h41, 32'h0, "no attach on SE0");
    bus.drive_line(upi_pkg::LS_J);
    tick(LC + 8);
    rd(A_F, d, r);
    chk(d & 32'h40, 32'h40, "attach");
    bus.drive_line(upi_pkg::LS_SE0);
    tick(LC + 8);
    rd(A_F, d, r);
    chk(d & 32'h01, 32'h01, "detach");
    wr(A_E, 32'h01);
    tick(1);
    chk(32'(module_interrupt_request), 32'h1, "detach irq");
    host_mode_enable <= 1'b0;
    // suspend with sleep guard, then activity on the line
    wr(A_P, 32'h13);
    chk(32'({usb_clk_en, xcvr_low_power}), 32'h1, "suspend");
    wr(A_E, 32'h20);
    wr(A_F, 32'hFF);
    bus.drive_line(upi_pkg::LS_K);
    tick(4);
    rd(A_P, d, r);
    chk(d & 32'h80, 32'h80, "activity pending");
    chk(32'(sleep_block), 32'h1, "sleep blocked");
    tick(LC + 8);
    rd(A_P, d, r);
    chk(d & 32'h80, 32'h0, "pending served");
    wr(A_P, 32'h03);
    tick(2);
    chk(32'(sleep_block), 32'h0, "guard off");
    wr(A_F, 32'hFF);
    wr(A_E, 32'h0);
    wr(A_P, 32'h00);
    rd(A_P, d, r);
    chk(d, 32'h08, "settling busy");
    chk(32'({analog_en, pins_owned, usb_clk_en}), 32'h0, "off");
    tick(12);
    rd(A_P, d, r);
    chk(d, 32'h0, "ready to enable");
    conclude();
  end
endmodule // usb_power_and_interrupt_ctrl_test
